// file: pic_ctrl.sv
// prioritised interrupt controller with axi4-lite register access
//
// Operation
// - non-maskable taken always, entry sets level 3
// - reset or trap wakes from halt
// - trap instruction raises trap request
// - trap routine stays preemptible by top-level
// - reset highest, starts at level 3
// - maskable needs enable and priority above level
// - chosen top-level pin edge raises request
// - external pins wake halt, sense programmable
// - edge external latched, cleared on entry
// - enabled pins of a group are ORed
// - peripheral request is flag and enable
// - peripheral clear sequence discards pending latch
// - any source wakes from wait
// - halt exit first services halt-capable source
// - non-halt source follows right after that
// - concurrent and nested management modes
// - fixed order line4 up to top-level
// - each maskable line has own priority
// - highest software priority, ties by hardware
// - top-level, reset, trap rank above all
//
// Our own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none

module pic_ctrl #(
  parameter int unsigned PINS     = pic_pkg::PINS_DEF,
  parameter int unsigned N_PERIPH = pic_pkg::N_PERIPH_DEF,
  parameter int unsigned STACK    = pic_pkg::STACK_DEF,
  parameter logic [N_PERIPH-1:0] PERIPH_HALT_CAP = '0
) (
  input  wire logic                                 clk_in,            // cpu clock
  input  wire logic                                 rst_n_in,          // async reset, low
  input  wire logic                                 tli_pin_in,        // top_level_pin_interrupt pin
  input  wire logic [pic_pkg::N_EXT*PINS-1:0]       ext_pin_in,        // external pins, grouped
  input  wire logic [N_PERIPH-1:0]                  periph_flag_in,    // peripheral status flags
  input  wire logic [N_PERIPH-1:0]                  periph_en_in,      // peripheral enable bits
  input  wire logic                                 periph_clear_in,   // clear sequence done
  input  wire logic                                 trap_exec_in,      // core executes trap
  input  wire logic                                 entry_ack_in,      // core took entry
  input  wire logic                                 iret_in,           // core returns
  input  wire logic                                 wait_enter_in,     // core enters wait
  input  wire logic                                 halt_enter_in,     // core enters halt
  output pic_pkg::pic_entry_s                       entry_out,         // request and vector
  output logic [1:0]                                level_out,         // level_bit_high, level_bit_low
  output logic                                      wake_out,          // wake pulse
  output logic                                      halted_out,        // in halt
  output logic                                      waiting_out,       // in wait
  input  wire logic [pic_pkg::AXI_ADDR_W-1:0]       s_axi_awaddr,      // write address
  input  wire logic                                 s_axi_awvalid,     // write address valid
  output logic                                      s_axi_awready,     // write address ready
  input  wire logic [pic_pkg::AXI_DATA_W-1:0]       s_axi_wdata,       // write data
  input  wire logic [pic_pkg::AXI_DATA_W/8-1:0]     s_axi_wstrb,       // byte strobes
  input  wire logic                                 s_axi_wvalid,      // write data valid
  output logic                                      s_axi_wready,      // write data ready
  output logic [1:0]                                s_axi_bresp,       // write response
  output logic                                      s_axi_bvalid,      // write response valid
  input  wire logic                                 s_axi_bready,      // write response ready
  input  wire logic [pic_pkg::AXI_ADDR_W-1:0]       s_axi_araddr,      // read address
  input  wire logic                                 s_axi_arvalid,     // read address valid
  output logic                                      s_axi_arready,     // read address ready
  output logic [pic_pkg::AXI_DATA_W-1:0]            s_axi_rdata,       // read data
  output logic [1:0]                                s_axi_rresp,       // read response
  output logic                                      s_axi_rvalid,      // read data valid
  input  wire logic                                 s_axi_rready       // read data ready
);

  localparam int unsigned PW = pic_pkg::N_EXT * PINS;
  localparam int unsigned NE = pic_pkg::N_EXT;
  localparam int unsigned NL = pic_pkg::N_LINES;
  localparam int unsigned DW = $clog2(STACK + 1);
  localparam logic [DW-1:0] DEPTH_MAX = DW'(STACK);

  typedef struct packed {
    logic [PW-1:0]          pin_s1;
    logic [PW-1:0]          pin_s2;
    logic [PW-1:0]          pin_prev;
    logic [2:0]             tli_sync;    // [0] first stage, [1] second, [2] previous
    logic [NE-1:0]          ext_latch;
    logic                   periph_latch;
    logic                   trap_pend;
    logic                   tli_pend;
    logic                   reset_pend;
    logic [1:0]             level;
    logic [STACK-1:0][1:0]  stack;
    logic [DW-1:0]          depth;
    pic_pkg::pic_lp_e       lp;
    logic                   halt_exit;
    logic                   wake;
    logic                   req_valid;
    logic [2:0]             req_vec;
    logic [1:0]             ctrl;
    logic [7:0]             sense;
    logic [9:0]             prio;
    logic [4:0]             enable;
    logic [PW-1:0]          pin_en;
    logic                   aw_have;
    logic [7:0]             aw_addr;
    logic                   w_have;
    logic [31:0]            wdata;
    logic [3:0]             wstrb;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   rvalid;
    logic [31:0]            rdata;
    logic [1:0]             rresp;
  } pic_state_s;

  pic_state_s st_ff;
  pic_state_s nxt_st;

  ////////////////////////////////////////////////////////////////////////////////
  // per-group trigger detection
  logic [NE-1:0] grp_low;
  logic [NE-1:0] grp_trig;

  genvar g;
  generate
    for (g = 0; g < NE; g++) begin : g_grp
      logic [PINS-1:0] cur;
      logic [PINS-1:0] prv;
      logic [PINS-1:0] en;
      logic            rise;
      logic            fall;
      assign cur  = st_ff.pin_s2[g*PINS +: PINS];
      assign prv  = st_ff.pin_prev[g*PINS +: PINS];
      assign en   = st_ff.pin_en[g*PINS +: PINS];
      assign rise = |(cur & ~prv & en);
      assign fall = |(~cur & prv & en);
      assign grp_low[g] = |(~cur & en);
      always_comb begin
        unique case (st_ff.sense[2*g +: 2])
          pic_pkg::SENSE_RISE: grp_trig[g] = rise;
          pic_pkg::SENSE_FALL: grp_trig[g] = fall;
          pic_pkg::SENSE_BOTH: grp_trig[g] = rise | fall;
          default:             grp_trig[g] = 1'b0;
        endcase
      end
    end
  endgenerate

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = val[8*b +: 8];
      end
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // next state
  logic [NL-1:0] pend;
  logic [NL-1:0] halt_ok;
  logic          periph_act;
  logic          periph_halt_act;
  logic          found;
  logic [2:0]    best_p;
  logic [2:0]    best_v;
  logic          eligible;
  logic          take;
  logic          tli_edge;
  logic [31:0]   wr;
  logic [31:0]   rd;
  logic          rd_ok;
  logic          wr_ok;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.wake = 1'b0;

    // sampled pins, second stage feeds all logic
    nxt_st.pin_s1      = ext_pin_in;
    nxt_st.pin_s2      = st_ff.pin_s1;
    nxt_st.pin_prev    = st_ff.pin_s2;
    nxt_st.tli_sync    = {st_ff.tli_sync[1], st_ff.tli_sync[0], tli_pin_in};

    periph_act      = |(periph_flag_in & periph_en_in);
    periph_halt_act = |(periph_flag_in & periph_en_in & PERIPH_HALT_CAP);
    for (int i = 0; i < NL; i++) begin
      pend[i]    = 1'b0;
      halt_ok[i] = 1'b1;
    end
    for (int i = 0; i < NE; i++) begin
      pend[i] = (st_ff.sense[2*i +: 2] == pic_pkg::SENSE_LOW) ? grp_low[i] : st_ff.ext_latch[i];
    end
    pend[pic_pkg::PERIPH_LINE]    = st_ff.periph_latch;
    halt_ok[pic_pkg::PERIPH_LINE] = periph_halt_act;

    // arbitration: lowest hardware line first so that ties go to the higher one
    found  = 1'b0;
    best_p = '0;
    best_v = '0;
    for (int i = NL - 1; i >= 0; i--) begin
      eligible = pend[i] & st_ff.enable[i]
               & (!st_ff.halt_exit | halt_ok[i])
               & (st_ff.prio[2*i +: 2] > st_ff.level)
               & (st_ff.ctrl[pic_pkg::CTRL_NESTED_BIT] | (st_ff.depth == '0));
      if (eligible && (!found || {1'b0, st_ff.prio[2*i +: 2]} >= best_p)) begin
        found  = 1'b1;
        best_p = {1'b0, st_ff.prio[2*i +: 2]};
        best_v = pic_pkg::VEC_LINE0 + 3'(i);
      end
    end
    if (st_ff.trap_pend) begin
      found  = 1'b1;
      best_p = pic_pkg::PRIO_NMI;
      best_v = pic_pkg::VEC_TRAP;
    end
    if (st_ff.tli_pend) begin
      found  = 1'b1;
      best_p = pic_pkg::PRIO_NMI;
      best_v = pic_pkg::VEC_TLI;
    end
    if (st_ff.reset_pend) begin
      found  = 1'b1;
      best_v = pic_pkg::VEC_RESET;
    end

    // return pops the level saved at entry
    if (iret_in && st_ff.depth != '0) begin
      nxt_st.depth = st_ff.depth - DW'(1);
      nxt_st.level = st_ff.stack[nxt_st.depth];
    end

    // entry accepted by the core
    take = entry_ack_in & st_ff.req_valid;
    if (take) begin
      nxt_st.halt_exit = 1'b0;
      if (st_ff.req_vec == pic_pkg::VEC_RESET) begin
        nxt_st.reset_pend = 1'b0;                                                // no context is saved
        nxt_st.level      = pic_pkg::LEVEL_TOP;
      end else begin
        // overflow beyond STACK entries is silent, as on the real stack
        if (nxt_st.depth != DEPTH_MAX) begin
          nxt_st.stack[nxt_st.depth] = nxt_st.level;
          nxt_st.depth               = nxt_st.depth + DW'(1);
        end
        if (st_ff.req_vec == pic_pkg::VEC_TRAP) begin
          nxt_st.trap_pend = 1'b0;
          nxt_st.level     = pic_pkg::LEVEL_TOP;
        end else if (st_ff.req_vec == pic_pkg::VEC_TLI) begin
          nxt_st.tli_pend = 1'b0;
          nxt_st.level    = pic_pkg::LEVEL_TOP;
        end else begin
          for (int i = 0; i < NL; i++) begin
            if (st_ff.req_vec == pic_pkg::VEC_LINE0 + 3'(i)) begin
              nxt_st.level = st_ff.prio[2*i +: 2];
              if (i < NE) begin
                nxt_st.ext_latch[i] = 1'b0;
              end
            end
          end
        end
      end
    end
    nxt_st.req_valid = found & ~take;
    nxt_st.req_vec   = best_v;

    // sources; a set in the same cycle as a clear wins
    if (periph_clear_in) begin
      nxt_st.periph_latch = 1'b0;
    end
    if (periph_act) begin
      nxt_st.periph_latch = 1'b1;
    end
    for (int i = 0; i < NE; i++) begin
      if (grp_trig[i]) begin
        nxt_st.ext_latch[i] = 1'b1;
      end
    end
    if (trap_exec_in) begin
      nxt_st.trap_pend = 1'b1;
    end
    tli_edge = st_ff.ctrl[pic_pkg::CTRL_TLI_RISE_BIT] ? (st_ff.tli_sync[1] & ~st_ff.tli_sync[2])
                                                      : (~st_ff.tli_sync[1] & st_ff.tli_sync[2]);
    if (tli_edge) begin
      nxt_st.tli_pend = 1'b1;
    end

    // low power modes
    unique case (st_ff.lp)
      pic_pkg::PIC_RUN: begin
        if (halt_enter_in) begin
          nxt_st.lp = pic_pkg::PIC_HALT;
        end else if (wait_enter_in) begin
          nxt_st.lp = pic_pkg::PIC_WAIT;
        end
      end
      pic_pkg::PIC_WAIT: begin
        if ((|pend) || st_ff.trap_pend || st_ff.tli_pend) begin
          nxt_st.lp   = pic_pkg::PIC_RUN;
          nxt_st.wake = 1'b1;
        end
      end
      pic_pkg::PIC_HALT: begin
        if ((|pend[NE-1:0]) || (st_ff.periph_latch && periph_halt_act)
            || st_ff.trap_pend) begin
          nxt_st.lp        = pic_pkg::PIC_RUN;
          nxt_st.wake      = 1'b1;
          nxt_st.halt_exit = 1'b1;
        end
      end
      default: nxt_st.lp = pic_pkg::PIC_RUN;
    endcase

    // axi4-lite write path
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_st.aw_have = 1'b1;
      nxt_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_st.w_have = 1'b1;
      nxt_st.wdata  = s_axi_wdata;
      nxt_st.wstrb  = s_axi_wstrb;
    end
    wr    = '0;
    wr_ok = 1'b1;
    if (st_ff.aw_have && st_ff.w_have && !st_ff.bvalid) begin
      unique case (st_ff.aw_addr)
        pic_pkg::OFS_CTRL: begin
          wr = merge(32'(st_ff.ctrl), st_ff.wdata, st_ff.wstrb);
          nxt_st.ctrl = wr[1:0];
        end
        pic_pkg::OFS_SENSE: begin
          wr = merge(32'(st_ff.sense), st_ff.wdata, st_ff.wstrb);
          nxt_st.sense = wr[7:0];
        end
        pic_pkg::OFS_PRIO: begin
          wr = merge(32'(st_ff.prio), st_ff.wdata, st_ff.wstrb);
          nxt_st.prio = wr[9:0];
        end
        pic_pkg::OFS_ENABLE: begin
          wr = merge(32'(st_ff.enable), st_ff.wdata, st_ff.wstrb);
          nxt_st.enable = wr[4:0];
        end
        pic_pkg::OFS_PIN_EN: begin
          wr = merge(32'(st_ff.pin_en), st_ff.wdata, st_ff.wstrb);
          nxt_st.pin_en = wr[PW-1:0];
        end
        pic_pkg::OFS_STATUS: wr_ok = 1'b1;                                       // read only, ignored
        default:             wr_ok = 1'b0;
      endcase
      nxt_st.aw_have = 1'b0;
      nxt_st.w_have  = 1'b0;
      nxt_st.bvalid  = 1'b1;
      nxt_st.bresp   = wr_ok ? pic_pkg::RESP_OKAY : pic_pkg::RESP_SLVERR;
    end else if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end

    // axi4-lite read path
    rd    = '0;
    rd_ok = 1'b1;
    unique case (s_axi_araddr)
      pic_pkg::OFS_CTRL:   rd = 32'(st_ff.ctrl);
      pic_pkg::OFS_SENSE:  rd = 32'(st_ff.sense);
      pic_pkg::OFS_PRIO:   rd = 32'(st_ff.prio);
      pic_pkg::OFS_ENABLE: rd = 32'(st_ff.enable);
      pic_pkg::OFS_PIN_EN: rd = 32'(st_ff.pin_en);
      pic_pkg::OFS_STATUS: begin
        rd[pic_pkg::STAT_PEND_LSB +: NL]    = pend;
        rd[pic_pkg::STAT_TRAP_BIT]          = st_ff.trap_pend;
        rd[pic_pkg::STAT_TLI_BIT]           = st_ff.tli_pend;
        rd[pic_pkg::STAT_RESET_BIT]         = st_ff.reset_pend;
        rd[pic_pkg::STAT_LEVEL_LSB +: 2]    = st_ff.level;
        rd[pic_pkg::STAT_LP_LSB +: 2]       = st_ff.lp;
        rd[pic_pkg::STAT_DEPTH_LSB +: DW]   = st_ff.depth;
      end
      default: rd_ok = 1'b0;
    endcase
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata  = rd;
      nxt_st.rresp  = rd_ok ? pic_pkg::RESP_OKAY : pic_pkg::RESP_SLVERR;
    end else if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_ff            <= '0;
      st_ff.reset_pend <= 1'b1;
      st_ff.level      <= pic_pkg::LEVEL_TOP;
      st_ff.ctrl       <= pic_pkg::CTRL_RESET;
      st_ff.sense      <= pic_pkg::SENSE_RESET;
      st_ff.prio       <= pic_pkg::PRIO_RESET;
      st_ff.enable     <= pic_pkg::ENABLE_RESET;
      st_ff.pin_s1     <= '1;
      st_ff.pin_s2     <= '1;
      st_ff.pin_prev   <= '1;
      st_ff.tli_sync   <= '1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs
  assign entry_out.valid = st_ff.req_valid;
  assign entry_out.vec   = st_ff.req_vec;
  assign level_out       = st_ff.level;
  assign wake_out        = st_ff.wake;
  assign halted_out      = (st_ff.lp == pic_pkg::PIC_HALT);
  assign waiting_out     = (st_ff.lp == pic_pkg::PIC_WAIT);
  assign s_axi_awready   = ~st_ff.aw_have & ~st_ff.bvalid;
  assign s_axi_wready    = ~st_ff.w_have & ~st_ff.bvalid;
  assign s_axi_bvalid    = st_ff.bvalid;
  assign s_axi_bresp     = st_ff.bresp;
  assign s_axi_arready   = ~st_ff.rvalid;
  assign s_axi_rvalid    = st_ff.rvalid;
  assign s_axi_rdata     = st_ff.rdata;
  assign s_axi_rresp     = st_ff.rresp;

endmodule

`default_nettype wire

// file: pic_pkg.sv
// constants, types and register map of the prioritised interrupt controller
`default_nettype none

package pic_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // bus and register map
  localparam int unsigned AXI_ADDR_W   = 8;
  localparam int unsigned AXI_DATA_W   = 32;
  localparam logic [7:0]  OFS_CTRL     = 8'h00;
  localparam logic [7:0]  OFS_SENSE    = 8'h04;  // ext_irq_sense_control
  localparam logic [7:0]  OFS_PRIO     = 8'h08;  // software_priority_regs
  localparam logic [7:0]  OFS_ENABLE   = 8'h0C;
  localparam logic [7:0]  OFS_PIN_EN   = 8'h10;
  localparam logic [7:0]  OFS_STATUS   = 8'h14;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  ////////////////////////////////////////////////////////////////////////////////
  // sources and fields
  localparam int unsigned N_LINES      = 5;      // hw_priority_line_0 .. hw_priority_line_4
  localparam int unsigned N_EXT        = 4;      // lines 0..3 are external pin groups
  localparam int unsigned PERIPH_LINE  = 4;
  localparam int unsigned PINS_DEF     = 4;      // pins per external group
  localparam int unsigned N_PERIPH_DEF = 8;
  localparam int unsigned STACK_DEF    = 8;

  localparam int unsigned CTRL_NESTED_BIT   = 0;
  localparam int unsigned CTRL_TLI_RISE_BIT = 1;
  localparam logic [1:0]  CTRL_RESET        = 2'h0;
  localparam logic [7:0]  SENSE_RESET       = 8'h00;
  localparam logic [9:0]  PRIO_RESET        = 10'h3FF;
  localparam logic [4:0]  ENABLE_RESET      = 5'h00;

  localparam logic [1:0]  SENSE_LOW   = 2'h0;
  localparam logic [1:0]  SENSE_RISE  = 2'h1;
  localparam logic [1:0]  SENSE_FALL  = 2'h2;
  localparam logic [1:0]  SENSE_BOTH  = 2'h3;

  localparam logic [1:0]  LEVEL_TOP   = 2'h3;
  localparam logic [2:0]  PRIO_NMI    = 3'h4;    // above any programmable level

  localparam int unsigned STAT_PEND_LSB  = 0;
  localparam int unsigned STAT_TRAP_BIT  = 5;
  localparam int unsigned STAT_TLI_BIT   = 6;
  localparam int unsigned STAT_RESET_BIT = 7;
  localparam int unsigned STAT_LEVEL_LSB = 8;
  localparam int unsigned STAT_LP_LSB    = 10;
  localparam int unsigned STAT_DEPTH_LSB = 12;

  localparam logic [2:0]  VEC_RESET   = 3'h0;
  localparam logic [2:0]  VEC_TRAP    = 3'h1;
  localparam logic [2:0]  VEC_TLI     = 3'h2;
  localparam logic [2:0]  VEC_LINE0   = 3'h3;    // line i is VEC_LINE0 + i

  typedef enum logic [1:0] {PIC_RUN, PIC_WAIT, PIC_HALT} pic_lp_e;

  typedef struct packed {
    logic       valid;
    logic [2:0] vec;
  } pic_entry_s;

endpackage

`default_nettype wire

// file: pic_ctrl_assertions.sv
// checker bound to the interrupt controller ports
`timescale 1ns/100ps
`default_nettype none
module pic_chk (
  input wire logic                clk_in,       // clock
  input wire logic                rst_n_in,     // reset
  input wire pic_pkg::pic_entry_s entry_out,    // request
  input wire logic [1:0]          level_out,    // level
  input wire logic                entry_ack_in, // take
  input wire logic                iret_in,      // return
  input wire logic                trap_exec_in, // trap
  input wire logic                halted_out,   // halt
  input wire logic                waiting_out,  // wait
  input wire logic                wake_out,     // wake
  input wire logic                s_axi_bvalid, // bvalid
  input wire logic                s_axi_bready, // bready
  input wire logic                s_axi_rvalid, // rvalid
  input wire logic                s_axi_rready  // rready
);
  logic took;
  assign took = entry_ack_in && entry_out.valid;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  ////////////////////////////////////////
  property p_nmi; took && entry_out.vec < pic_pkg::VEC_LINE0 |=> level_out == pic_pkg::LEVEL_TOP; endproperty
  a_nmi: assert property (p_nmi) else $error("nmi level");
  property p_drop; took |=> !entry_out.valid; endproperty
  a_drop: assert property (p_drop) else $error("no drop");
  property p_trap; trap_exec_in |-> ##[1:8] entry_out.valid; endproperty
  a_trap: assert property (p_trap) else $error("no trap");
  property p_hwake; halted_out && trap_exec_in |-> ##[1:6] wake_out; endproperty
  a_hwake: assert property (p_hwake) else $error("halt stuck");
  property p_run; wake_out |-> !halted_out && !waiting_out ##1 !wake_out; endproperty
  a_run: assert property (p_run) else $error("wake state");
  property p_lvl; level_out != $past(level_out) |-> $past(entry_ack_in || iret_in); endproperty
  a_lvl: assert property (p_lvl) else $error("level moved");
  property p_bh; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_bh: assert property (p_bh) else $error("bvalid drop");
  property p_rh; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid; endproperty
  a_rh: assert property (p_rh) else $error("rvalid drop");
  c_took: cover property (took);
  c_wake: cover property (wake_out);
  c_halt: cover property (halted_out && trap_exec_in);
endmodule
bind pic_ctrl pic_chk u_chk (.*);
`default_nettype wire

// file: pic_core_model.sv
// core model: takes entries after a set delay, returns later except from reset
`timescale 1ns/100ps
`default_nettype none
module pic_core_model (
  input wire logic                clk_in,   // clock
  input wire logic                rst_n_in, // reset
  input wire pic_pkg::pic_entry_s entry_in, // request
  input wire logic [3:0]          dly_in,   // take delay
  output logic                    ack_out,  // take
  output logic                    iret_out  // return
);
  logic [3:0] wait_ff;
  logic [3:0] run_ff;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      {ack_out, iret_out, wait_ff, run_ff} <= '0;
    end else begin
      ack_out <= entry_in.valid && !ack_out && wait_ff == dly_in;
      iret_out <= run_ff == 4'h1;
      if (entry_in.valid && !ack_out)
        wait_ff <= (wait_ff == dly_in) ? 4'h0 : wait_ff + 4'h1;
      // reset routine is the main program, it never returns
      if (ack_out && entry_in.valid && entry_in.vec != pic_pkg::VEC_RESET)
        run_ff <= 4'hA;
      else if (run_ff != 4'h0)
        run_ff <= run_ff - 4'h1;
    end
  end
endmodule
`default_nettype wire

// file: pic_ctrl_test.sv
// self-checking bench for the interrupt controller
`timescale 1ns/100ps
`default_nettype none
module pic_ctrl_test;
  logic clk_in = 1'b0, rst_n_in = 1'b0, tli_pin_in = 1'b1, trap_exec_in = 1'b0, periph_clear_in = 1'b0;
  logic wait_enter_in = 1'b0, halt_enter_in = 1'b0, entry_ack_in, iret_in, wake_out, halted_out, waiting_out;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [15:0] ext_pin_in = '0, pe;
  logic [7:0] periph_flag_in = '0, periph_en_in = '0, s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, d, rnd = 32'hCB79C6A9;
  logic [3:0] s_axi_wstrb = 4'hF, dly = 4'h0, p;
  logic [1:0] s_axi_bresp, s_axi_rresp, level_out, r;
  logic [4:0] ep = '0;
  logic [2:0] vq[$];
  pic_pkg::pic_entry_s entry_out;
  int miscompares = 0, samples_checked = 0, cycles = 0, wakes = 0, k;
  pic_ctrl dut (.*);
  pic_core_model core (.clk_in, .rst_n_in, .entry_in(entry_out), .dly_in(dly), .ack_out(entry_ack_in), .iret_out(iret_in));
  always #2.5 clk_in = ~clk_in;
  ////////////////////////////////////////
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [4:0] pend_of(input logic [15:0] en, input logic [3:0] pin);
    return en[pin] ? 5'h1 << pin[3:2] : 5'h0;
  endfunction
  task automatic tk(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ready and answer are read mid-cycle, where they have settled
  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    logic [2:0] hs;
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, v, 3'h7};
    do begin
      @(negedge clk_in);
      {hs, r} = {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bresp};
      @(posedge clk_in);
      if (hs[2]) s_axi_awvalid <= 1'b0;
      if (hs[1]) s_axi_wvalid <= 1'b0;
    end while (hs[0] !== 1'b1);
    chk("bresp", pic_pkg::RESP_OKAY, r);
  endtask
  task automatic axr(input logic [7:0] a);
    logic [1:0] hs;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    do begin
      @(negedge clk_in);
      {hs, d, r} = {s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
      @(posedge clk_in);
      if (hs[1]) s_axi_arvalid <= 1'b0;
    end while (hs[0] !== 1'b1);
  endtask
  task automatic pulse_trap;
    trap_exec_in <= 1'b1;
    tk(1);
    trap_exec_in <= 1'b0;
  endtask
  task automatic nmi(input logic [3:0] dl, input int gap, input logic [2:0] v0, input logic [2:0] v1);
    vq.delete();
    dly <= dl;
    pulse_trap();
    tk(gap);
    tli_pin_in <= 1'b1;
    tk(60);
    tli_pin_in <= 1'b0;
    tk(8);
    chk("nmi_count", 32'h2, vq.size());
    chk("nmi_first", v0, vq[0]);
    chk("nmi_second", v1, vq[1]);
    $display("test nmi order done");
  endtask
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if ((entry_ack_in & entry_out.valid) === 1'b1)
      vq.push_back(entry_out.vec);
    if (wake_out === 1'b1)
      wakes <= wakes + 1;
    if (cycles == 3000) begin
      miscompares++;
      $display("MISMATCH timeout expected %0d seen %0d", 3000, cycles);
      wrap_up();
    end
  end
  initial begin
    tk(6);
    rst_n_in <= 1'b1;
    tk(12);
    chk("reset_vec", {29'h0, pic_pkg::VEC_RESET}, vq.size() == 1 ? vq[0] : 3'h7);
    chk("level", pic_pkg::LEVEL_TOP, level_out);
    axr(pic_pkg::OFS_PRIO);
    chk("prio", pic_pkg::PRIO_RESET, d);
    axr(8'h18);
    chk("unmapped", pic_pkg::RESP_SLVERR, r);
    axw(pic_pkg::OFS_STATUS, 32'hFFFFFFFF);
    axr(pic_pkg::OFS_STATUS);
    chk("status", 32'h300, d);
    halt_enter_in <= 1'b1;
    tk(1);
    halt_enter_in <= 1'b0;
    tk(4);
    chk("halted", 32'h1, halted_out);
    vq.delete();
    pulse_trap();
    tk(30);
    chk("halt_wake", 32'h1, wakes);
    chk("trap_vec", pic_pkg::VEC_TRAP, vq[0]);
    axw(pic_pkg::OFS_CTRL, 32'h2);
    tli_pin_in <= 1'b0;
    tk(5);
    nmi(4'h9, 0, pic_pkg::VEC_TLI, pic_pkg::VEC_TRAP);
    nmi(4'h0, 6, pic_pkg::VEC_TRAP, pic_pkg::VEC_TLI);
    axw(pic_pkg::OFS_SENSE, 32'h55);
    axw(pic_pkg::OFS_ENABLE, 32'h1F);
    rnd = nx(rnd);
    pe = rnd[15:0] | 16'h1;
    axw(pic_pkg::OFS_PIN_EN, {16'h0, pe});
    for (int i = 0; i < 6; i++) begin
      rnd = nx(rnd);
      p = i ? rnd[3:0] : 4'h0;
      ext_pin_in <= 16'h1 << p;
      tk(5);
      ext_pin_in <= '0;
      tk(5);
      ep |= pend_of(pe, p);
      axr(pic_pkg::OFS_STATUS);
      chk("ext_pending", ep, d[4:0]);
    end
    for (int j = 0; j < 2; j++) begin
      k = wakes;
      {wait_enter_in, halt_enter_in} <= j ? 2'h1 : 2'h2;
      tk(1);
      {wait_enter_in, halt_enter_in} <= 2'h0;
      tk(8);
      chk("lp_wake", k + 1, wakes);
      chk("lp_run", 32'h0, {halted_out, waiting_out});
    end
    for (int m = 0; m < 4; m++) begin
      periph_flag_in <= m != 2 ? 8'h1 << rnd[6:4] : 8'h0;
      periph_en_in <= m[0] ? 8'h1 << rnd[6:4] : 8'h0;
      periph_clear_in <= m[1];
      tk(1);
      periph_clear_in <= 1'b0;
      tk(3);
      axr(pic_pkg::OFS_STATUS);
      chk("periph_pending", m[0], d[pic_pkg::PERIPH_LINE]);
    end
    $display("test pins done");
    wrap_up();
  end
endmodule
`default_nettype wire
